/* File: verilog/sdo_abort_pkg.sv */
/*
 sdo_abort_pkg: abort codes, fault flag layout, frame layout and timing constants
 for the sdo abort code generator.
 assumes: single clock domain at 100 MHz, synchronous active-high reset.
*/
package sdo_abort_pkg;

    localparam logic [31:0] ABORT_TOGGLE = 32'h05030000;
    localparam logic [31:0] ABORT_TIMEOUT = 32'h05040000;
    localparam logic [31:0] ABORT_BAD_CMD = 32'h05040001;
    localparam logic [31:0] ABORT_MEM_OVF = 32'h05040005;
    localparam logic [31:0] ABORT_NO_ACCESS = 32'h06010000;
    localparam logic [31:0] ABORT_READ_WO = 32'h06010001;
    localparam logic [31:0] ABORT_WRITE_RO = 32'h06010002;
    localparam logic [31:0] ABORT_NO_OBJECT = 32'h06020000;
    localparam logic [31:0] ABORT_NOT_MAPPABLE = 32'h06040041;
    localparam logic [31:0] ABORT_MAP_TOO_LONG = 32'h06040042;
    localparam logic [31:0] ABORT_LEN_HIGH = 32'h06070012;
    localparam logic [31:0] ABORT_LEN_LOW = 32'h06070013;
    localparam logic [31:0] ABORT_NO_SUBINDEX = 32'h06090011;
    localparam logic [31:0] ABORT_RANGE = 32'h06090030;
    localparam logic [31:0] ABORT_TOO_HIGH = 32'h06090031;
    localparam logic [31:0] ABORT_TOO_LOW = 32'h06090032;
    localparam logic [31:0] ABORT_MAX_LT_MIN = 32'h06090036;
    localparam logic [31:0] ABORT_GENERAL = 32'h08000000;
    localparam logic [31:0] ABORT_APP_STORE = 32'h08000020;
    localparam logic [31:0] ABORT_LOCAL_CTRL = 32'h08000021;

    // abort command specifier byte of the published sdo protocol
    localparam logic [7:0] CS_ABORT = 8'h80;
    // command specifier field and toggle bit position in byte 0
    localparam int CS_FIELD_LSB = 5;
    localparam int TOGGLE_BIT = 4;
    localparam logic [2:0] CCS_DL_SEG = 3'h0;
    localparam logic [2:0] CCS_DL_INIT = 3'h1;
    localparam logic [2:0] CCS_UL_INIT = 3'h2;
    localparam logic [2:0] CCS_UL_SEG = 3'h3;
    localparam logic [2:0] CCS_ABORT = 3'h4;

    // transfer timeout in microseconds and its cycle count at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int SDO_TIMEOUT_US = 1000;
    localparam int SDO_TIMEOUT_CYC = SDO_TIMEOUT_US * CLK_MHZ;
    localparam int TMR_W = 24;

    localparam int FAULT_W = 19;

    // one bit per detected failure, priority from bit 0 upward
    typedef struct packed {
        logic general;
        logic local_ctrl;
        logic app_store;
        logic max_lt_min;
        logic too_low;
        logic too_high;
        logic range;
        logic len_low;
        logic len_high;
        logic map_too_long;
        logic not_mappable;
        logic no_subindex;
        logic no_object;
        logic write_ro;
        logic read_wo;
        logic no_access;
        logic mem_ovf;
        logic bad_cmd;
        logic timeout;
    } fault_s;

    // one received sdo request
    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] index;
        logic [7:0] subindex;
    } sdo_req_s;

    // outgoing 8-byte frame, byte 0 first
    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
        logic [7:0] b5;
        logic [7:0] b6;
        logic [7:0] b7;
    } sdo_frame_s;

endpackage

/* File: verilog/abort_code_select.sv */
/*
 abort_code_select: priority encoder from fault flags to a 4-byte abort code.
 assumes: purely combinational, flags stable while sampled by the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module abort_code_select
    import sdo_abort_pkg::*;
(
    input wire fault_s faults,
    output logic any_fault,
    output logic [31:0] code
);
    wire logic [FAULT_W-1:0] flat = faults;
    assign any_fault = |flat;

    always_comb begin
        code = ABORT_GENERAL;
        if (faults.timeout) code = ABORT_TIMEOUT;
        else if (faults.bad_cmd) code = ABORT_BAD_CMD;
        else if (faults.mem_ovf) code = ABORT_MEM_OVF;
        else if (faults.no_access) code = ABORT_NO_ACCESS;
        else if (faults.read_wo) code = ABORT_READ_WO;
        else if (faults.write_ro) code = ABORT_WRITE_RO;
        else if (faults.no_object) code = ABORT_NO_OBJECT;
        else if (faults.no_subindex) code = ABORT_NO_SUBINDEX;
        else if (faults.not_mappable) code = ABORT_NOT_MAPPABLE;
        else if (faults.map_too_long) code = ABORT_MAP_TOO_LONG;
        else if (faults.len_high) code = ABORT_LEN_HIGH;
        else if (faults.len_low) code = ABORT_LEN_LOW;
        else if (faults.range) code = ABORT_RANGE;
        else if (faults.too_high) code = ABORT_TOO_HIGH;
        else if (faults.too_low) code = ABORT_TOO_LOW;
        else if (faults.max_lt_min) code = ABORT_MAX_LT_MIN;
        else if (faults.app_store) code = ABORT_APP_STORE;
        else if (faults.local_ctrl) code = ABORT_LOCAL_CTRL;
    end
endmodule
`default_nettype wire

/* File: verilog/sdo_abort_code_generator.sv */
/*
 sdo_abort_code_generator: tracks sdo transfers from the master, builds abort
 frames with the reason code, and raises emergency requests on exceptions.
 assumes: request strobe and fault inputs come from logic on ref_clk; the
 object dictionary lookup is done outside and reported as fault flags with
 the request; frame_ready comes from the transmit logic on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sdo_abort_code_generator
    import sdo_abort_pkg::*;
#(
    parameter int TIMEOUT_CYC = SDO_TIMEOUT_CYC
)
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire sdo_req_s req,
    input wire fault_s req_faults,
    input wire logic req_segmented,
    input wire logic seg_done,
    input wire logic app_abort,
    input wire logic [31:0] app_abort_code,
    input wire logic master_abort,
    input wire logic comm_exception,
    input wire logic drive_exception,
    input wire logic frame_ready,
    output logic frame_valid,
    output sdo_frame_s frame,
    output logic xfer_active,
    output logic emcy_req,
    output logic [31:0] last_code
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_SEND = 2'b10
    } state_e;

    state_e state_reg, state_next;
    logic toggle_reg, toggle_next;
    logic [TMR_W-1:0] tmr_reg, tmr_next;
    logic [15:0] index_reg, index_next;
    logic [7:0] sub_reg, sub_next;
    sdo_frame_s frame_reg, frame_next;
    logic [31:0] code_reg, code_next;
    logic emcy_reg, exc_seen_reg;

    wire logic [2:0] ccs = req.cmd[CS_FIELD_LSB +: 3];
    wire logic seg_cmd = (ccs == CCS_DL_SEG) || (ccs == CCS_UL_SEG);
    wire logic init_cmd = (ccs == CCS_DL_INIT) || (ccs == CCS_UL_INIT);
    wire logic known_cmd = seg_cmd || init_cmd || (ccs == CCS_ABORT);
    wire logic toggle_bad = (state_reg == ST_XFER) && seg_cmd &&
                            (req.cmd[TOGGLE_BIT] != toggle_reg);
    wire logic timed_out = (state_reg == ST_XFER) &&
                           (tmr_reg == TMR_W'(TIMEOUT_CYC - 1));
    // a segment outside a transfer, or an unknown specifier, is a bad command
    wire logic cmd_bad = req_valid && (!known_cmd || (seg_cmd && state_reg != ST_XFER));

    fault_s eff_faults;
    always_comb begin
        eff_faults = req_valid ? req_faults : '0;
        eff_faults.timeout = timed_out;
        eff_faults.bad_cmd = cmd_bad || (req_valid && req_faults.bad_cmd);
    end

    logic any_fault;
    logic [31:0] sel_code;
    abort_code_select u_select (
        .faults(eff_faults),
        .any_fault(any_fault),
        .code(sel_code)
    );

    wire logic toggle_abort = req_valid && toggle_bad && !eff_faults.bad_cmd;
    wire logic [31:0] abort_code = app_abort ? app_abort_code :
                                   toggle_abort && !any_fault ? ABORT_TOGGLE :
                                   sel_code;
    wire logic do_abort = (state_reg != ST_SEND) &&
                          (app_abort || toggle_abort || any_fault);
    wire logic is_master_abort = req_valid && ccs == CCS_ABORT;
    wire logic [15:0] ab_index = req_valid ? req.index : index_reg;
    wire logic [7:0] ab_sub = req_valid ? req.subindex : sub_reg;

    always_comb begin
        state_next = state_reg;
        toggle_next = toggle_reg;
        tmr_next = tmr_reg;
        index_next = index_reg;
        sub_next = sub_reg;
        frame_next = frame_reg;
        code_next = code_reg;
        case (state_reg)
            ST_IDLE, ST_XFER: begin
                if (state_reg == ST_XFER) begin
                    tmr_next = tmr_reg + TMR_W'(1);
                end
                if (do_abort) begin
                    frame_next = '{CS_ABORT, ab_index[7:0], ab_index[15:8], ab_sub,
                                   abort_code[7:0], abort_code[15:8],
                                   abort_code[23:16], abort_code[31:24]};
                    code_next = abort_code;
                    state_next = ST_SEND;
                end else if (master_abort || is_master_abort) begin
                    state_next = ST_IDLE;
                end else if (req_valid && init_cmd) begin
                    index_next = req.index;
                    sub_next = req.subindex;
                    toggle_next = 1'b0;
                    tmr_next = '0;
                    state_next = req_segmented ? ST_XFER : ST_IDLE;
                end else if (req_valid && seg_cmd) begin
                    toggle_next = ~toggle_reg;
                    tmr_next = '0;
                    if (seg_done) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_SEND: begin
                if (frame_ready) begin
                    state_next = ST_IDLE;
                    toggle_next = 1'b0;
                    tmr_next = '0;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // emergency when either exception rises while both were low, apart from sdo state
    wire logic exc_now = comm_exception || drive_exception;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            toggle_reg <= 1'b0;
            tmr_reg <= '0;
            index_reg <= 16'h0000;
            sub_reg <= 8'h00;
            frame_reg <= '0;
            code_reg <= 32'h00000000;
            emcy_reg <= 1'b0;
            exc_seen_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            toggle_reg <= toggle_next;
            tmr_reg <= tmr_next;
            index_reg <= index_next;
            sub_reg <= sub_next;
            frame_reg <= frame_next;
            code_reg <= code_next;
            emcy_reg <= exc_now && !exc_seen_reg;
            exc_seen_reg <= exc_now;
        end
    end

    assign frame_valid = (state_reg == ST_SEND);
    assign frame = frame_reg;
    assign xfer_active = (state_reg == ST_XFER);
    assign emcy_req = emcy_reg;
    assign last_code = code_reg;
endmodule
`default_nettype wire

/* File: verification/sdo_abort_asserts.sv */
/* sdo_abort_asserts: port checks of the abort code generator.
 assumes: bound to sdo_abort_code_generator, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module sdo_abort_asserts
    import sdo_abort_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire sdo_req_s req,
    input wire fault_s req_faults,
    input wire logic drive_exception,
    input wire logic frame_ready,
    input wire logic frame_valid,
    input wire sdo_frame_s frame,
    input wire logic xfer_active,
    input wire logic emcy_req,
    input wire logic [31:0] last_code
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence s_held; frame_valid && !frame_ready; endsequence
    sequence s_taken; frame_valid && frame_ready; endsequence
    reset_clear_a: assert property (disable iff (1'b0) srst |=> !frame_valid && !xfer_active
        && !emcy_req && last_code == 32'h0) else $error("state not cleared by reset");
    frame_hold_a: assert property (s_held |=> frame_valid && $stable(frame))
        else $error("frame changed before acceptance");
    frame_release_a: assert property (s_taken |=> !frame_valid)
        else $error("frame still offered after acceptance");
    abort_spec_a: assert property (frame_valid |-> frame.b0 == CS_ABORT)
        else $error("wrong command specifier");
    code_order_a: assert property (frame_valid |-> {frame.b7, frame.b6, frame.b5, frame.b4}
        == last_code) else $error("code bytes out of order");
    fault_answer_a: assert property (req_valid && !frame_valid && req_faults != '0
        |=> frame_valid) else $error("fault not answered");
    frame_index_a: assert property ($rose(frame_valid) && $past(req_valid)
        |-> {frame.b2, frame.b1} == $past(req.index)) else $error("index mismatch");
    emcy_raise_a: assert property ($rose(drive_exception) |-> ##[1:2] emcy_req)
        else $error("no emergency request");
    emcy_pulse_a: assert property (emcy_req |=> !emcy_req)
        else $error("emergency request too long");
endmodule
`default_nettype wire

/* File: verification/abort_frame_sink.sv */
/* abort_frame_sink: master side that accepts abort frames and decodes them.
 assumes: stall comes from the bench; got_info keeps the last accepted frame until the next one. */
`timescale 1ns/1ps
`default_nettype none
module abort_frame_sink
    import sdo_abort_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic stall,
    input wire logic frame_valid,
    input wire sdo_frame_s frame,
    output logic frame_ready,
    output logic got,
    output logic [63:0] got_info
);
    assign frame_ready = frame_valid && !stall;
    always_ff @(posedge ref_clk) begin
        got <= !srst && frame_ready;
        if (frame_ready) begin
            got_info <= {frame.b0, frame.b2, frame.b1, frame.b3,
                         frame.b7, frame.b6, frame.b5, frame.b4};
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
/* tb: self-checking bench with a priority model of the abort codes.
 assumes: frame_ready from abort_frame_sink, short timeout parameter. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sdo_abort_pkg::*;
    logic ref_clk = 0, srst = 1, req_valid = 0, seg = 0, app_abort = 0, stall = 0;
    logic drive = 0, comm = 0, frame_valid, frame_ready, xfer_active, emcy_req, got;
    sdo_req_s req = '0;
    fault_s flt = '0;
    sdo_frame_s frame;
    logic [31:0] app_code = '0, last_code, lf = 32'h7bad;
    logic [63:0] got_info;
    logic [23:0] cur = '0;
    int mismatches = 0, checked = 0, n;
    logic [31:0] codes[19] = '{32'h05040000, 32'h05040001, 32'h05040005, 32'h06010000,
        32'h06010001, 32'h06010002, 32'h06020000, 32'h06090011, 32'h06040041, 32'h06040042,
        32'h06070012, 32'h06070013, 32'h06090030, 32'h06090031, 32'h06090032, 32'h06090036,
        32'h08000020, 32'h08000021, 32'h08000000};
    always #5 ref_clk = ~ref_clk;
    sdo_abort_code_generator #(.TIMEOUT_CYC(20)) dut (.ref_clk(ref_clk), .srst(srst),
        .req_valid(req_valid), .req(req), .req_faults(flt), .req_segmented(seg),
        .seg_done(1'b0), .app_abort(app_abort), .app_abort_code(app_code),
        .master_abort(1'b0), .comm_exception(comm), .drive_exception(drive),
        .frame_ready(frame_ready), .frame_valid(frame_valid), .frame(frame),
        .xfer_active(xfer_active), .emcy_req(emcy_req), .last_code(last_code));
    abort_frame_sink sink (.ref_clk(ref_clk), .srst(srst), .stall(stall),
        .frame_valid(frame_valid), .frame(frame), .frame_ready(frame_ready), .got(got),
        .got_info(got_info));
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic send(input logic [7:0] c, input fault_s f, input logic s, input logic nw);
        @(negedge ref_clk);
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        if (nw) cur = lf[23:0];
        req = '{c, cur[23:8], cur[7:0]};
        flt = f;
        seg = s;
        req_valid = 1;
        @(negedge ref_clk);
        req_valid = 0;
        app_abort = 0;
        seg = 0;
        flt = '0;
    endtask
    task automatic wait_frame(input logic [31:0] code);
        n = 0;
        while (got !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        chk(got_info, {8'h80, cur, code});
        chk({32'h0, last_code}, {32'h0, code});
        @(negedge ref_clk);
    endtask
    function automatic int pick(input fault_s f);
        // the timeout flag is ignored; timeouts come only from the timer
        for (int i = 1; i < 19; i++) if (f[i]) return i;
        return 18;
    endfunction
    task automatic tally_and_finish;
        if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        fault_s f;
        repeat (12) @(negedge ref_clk);
        srst = 0;
        chk({xfer_active, emcy_req, frame_valid, last_code}, 64'h0);
        for (int i = 1; i < 19; i++) begin
            send(8'h20, fault_s'(19'h1 << i), 0, 1);
            wait_frame(codes[i]);
        end
        for (int k = 0; k < 8; k++) begin
            f = fault_s'(lf[18:0] | 19'h40000);
            stall = 1;
            send(8'h20, f, 0, 1);
            repeat (4) @(negedge ref_clk);
            chk({63'h0, frame_valid}, 64'h1);
            stall = 0;
            wait_frame(codes[pick(f)]);
        end
        send(8'h20, '0, 1, 1);
        chk({63'h0, xfer_active}, 64'h1);
        send(8'h00, '0, 0, 0);
        send(8'h00, '0, 0, 0);
        wait_frame(32'h05030000);
        send(8'h10, '0, 0, 0);
        wait_frame(32'h05040001);
        for (int c = 5; c < 8; c++) begin
            send({c[2:0], 5'h0}, '0, 0, 1);
            wait_frame(32'h05040001);
        end
        send(8'h20, '0, 1, 1);
        wait_frame(32'h05040000);
        app_code = lf ^ 32'h5a5a0000;
        app_abort = 1;
        // app abort is taken one edge before the request, with the stored index
        send(8'h20, '0, 0, 0);
        wait_frame(app_code);
        for (int e = 0; e < 2; e++) begin
            @(negedge ref_clk);
            if (e == 0) drive = 1;
            else comm = 1;
            n = 0;
            while (emcy_req !== 1'b1 && n < 3) begin
                @(negedge ref_clk);
                n++;
            end
            chk({63'h0, emcy_req}, 64'h1);
            @(negedge ref_clk);
            chk({63'h0, emcy_req}, 64'h0);
            drive = 0;
            comm = 0;
        end
        tally_and_finish;
    end
    initial begin
        #100000;
        mismatches++;
        tally_and_finish;
    end
endmodule
bind sdo_abort_code_generator sdo_abort_asserts chk_i (.ref_clk(ref_clk), .srst(srst),
    .req_valid(req_valid), .req(req), .req_faults(req_faults),
    .drive_exception(drive_exception), .frame_ready(frame_ready),
    .frame_valid(frame_valid), .frame(frame), .xfer_active(xfer_active),
    .emcy_req(emcy_req), .last_code(last_code));
`default_nettype wire
